// File: hw/id_addr_decoder.sv
// maps a byte address onto one register of the bank
`timescale 1ns/10ps
`include "trace_id_regs.svh"
module id_addr_decoder (
    id_link_if.dec link
);
    // a misaligned address hits nothing, so it answers as unmapped
    wire aligned = (link.lookupAddr[1:0] == 2'h0);
    wire hitArch = aligned & (link.lookupAddr == `TID_ARCH_OFS);
    wire hitSize = aligned & (link.lookupAddr == `TID_SIZE_OFS);
    wire hitCfg = aligned & (link.lookupAddr == `TID_CFG_OFS);
    wire hitCtrl = aligned & (link.lookupAddr == `TID_CTRL_OFS);
    wire hitStat = aligned & (link.lookupAddr == `TID_STAT_OFS);
    wire hitThresh = aligned & (link.lookupAddr == `TID_THRESH_OFS);

    // priority chain; hits are exclusive anyway
    assign link.sel = hitArch ? trace_id_pkg::SEL_ARCH :
        hitSize ? trace_id_pkg::SEL_SIZE :
        hitCfg ? trace_id_pkg::SEL_CFG :
        hitCtrl ? trace_id_pkg::SEL_CTRL :
        hitStat ? trace_id_pkg::SEL_STAT :
        hitThresh ? trace_id_pkg::SEL_THRESH :
        trace_id_pkg::SEL_NONE;
endmodule : id_addr_decoder

// File: hw/id_link_if.sv
// words and decode signals passed between the bank's modules
`timescale 1ns/10ps
interface id_link_if;
    logic [31:0] archWord;
    logic [31:0] sizeWord;
    logic [31:0] cfgWord;
    logic [7:0] lookupAddr;
    trace_id_pkg::reg_sel_t sel;
    // word builder drives the constants
    modport rom (
        output archWord,
        output sizeWord,
        output cfgWord
    );
    // decoder turns an address into a selection
    modport dec (
        input lookupAddr,
        output sel
    );
    // bus core reads both
    modport core (
        input archWord,
        input sizeWord,
        input cfgWord,
        input sel,
        output lookupAddr
    );
endinterface : id_link_if

// File: hw/id_word_builder.sv
// builds the three fixed identification words
`timescale 1ns/10ps
`include "trace_id_regs.svh"
module id_word_builder #(
    parameter logic [7:0] DESIGNER_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h1, // arbitrary value
    parameter int CC_WIDTH = 12,
    parameter int PROC_COUNT = 1
) (
    id_link_if.rom link
);
    // or a value into a word at a bit position
    function automatic logic [31:0] put_field(
        input logic [31:0] word,
        input logic [31:0] value,
        input int lsb
    );
        put_field = word | (value << lsb);
    endfunction : put_field

    localparam logic [3:0] CC_CODE = 4'(CC_WIDTH - `TID_CCW_BASE);
    localparam logic [4:0] PROC_CODE = 5'(PROC_COUNT - 1);

    // architecture word, bits 23:16 stay zero
    assign link.archWord = put_field(put_field(put_field(put_field(
        put_field(32'h00000000, 32'(DESIGNER_CODE), `TID_DESIGNER_LSB),
        32'(`TID_RES1_VAL), `TID_RES1_LSB),
        32'(`TID_MAJOR_VAL), `TID_MAJOR_LSB),
        32'(`TID_MINOR_VAL), `TID_MINOR_LSB),
        32'(REVISION_CODE), `TID_REVISION_LSB);

    // size word, bits 31:29 stay zero
    assign link.sizeWord = put_field(put_field(put_field(put_field(
        put_field(put_field(32'h00000000,
        32'(CC_CODE), `TID_CCW_LSB),
        32'(`TID_UNSUPP_VAL), `TID_DVW_LSB),
        32'(`TID_UNSUPP_VAL), `TID_DAW_LSB),
        32'(`TID_UNSUPP_VAL), `TID_VMID_LSB),
        32'(`TID_UNSUPP_VAL), `TID_CTX_LSB),
        32'(`TID_IAW_VAL), `TID_IAW_LSB);

    // configuration word, bits 15:14 stay zero
    assign link.cfgWord = put_field(put_field(put_field(put_field(
        put_field(put_field(put_field(put_field(put_field(put_field(
        32'h00000000,
        32'(`TID_OVF_VAL), `TID_OVF_LSB),
        32'(PROC_CODE[2:0]), `TID_PROC_LO_LSB),
        32'(PROC_CODE[4:3]), `TID_PROC_HI_LSB),
        32'(`TID_FLAG_ON), `TID_SYSTEM_STALL_SUPPORT_LSB),
        32'(`TID_FLAG_ON), `TID_STALLREG_LSB),
        32'(`TID_FLAG_ON), `TID_SYNCFIX_LSB),
        32'(`TID_FLAG_ON), `TID_ERRTRACE_LSB),
        32'(`TID_NS_EL_VAL), `TID_NS_EL_LSB),
        32'(`TID_S_EL_VAL), `TID_S_EL_LSB),
        32'(`TID_MINCC_VAL), `TID_MINCC_LSB);
endmodule : id_word_builder

// File: hw/trace_id_pkg.sv
// types shared by the trace id register bank
package trace_id_pkg;
    // register selected by the decoder
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_ARCH = 3'h1,
        SEL_SIZE = 3'h2,
        SEL_CFG = 3'h3,
        SEL_CTRL = 3'h4,
        SEL_STAT = 3'h5,
        SEL_THRESH = 3'h6
    } reg_sel_t;
    // bus handshake states, gray along idle-lookup-answer
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOOKUP = 2'h1,
        ST_ANSWER = 2'h3
    } bus_state_t;
    // avalon response codes
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2,
        RESP_DECERR = 2'h3
    } resp_t;
endpackage : trace_id_pkg

// File: hw/trace_id_regs.svh
// offsets, field positions and fixed values of the trace id register bank
`ifndef TRACE_ID_REGS_SVH
`define TRACE_ID_REGS_SVH
`define TID_ADDR_W 8
`define TID_ARCH_OFS 8'h00
`define TID_SIZE_OFS 8'h04
`define TID_CFG_OFS 8'h08
`define TID_CTRL_OFS 8'h10
`define TID_STAT_OFS 8'h14
`define TID_THRESH_OFS 8'h18
`define TID_DESIGNER_LSB 24
`define TID_RES1_LSB 12
`define TID_RES1_VAL 4'hf
`define TID_MAJOR_LSB 8
`define TID_MAJOR_VAL 4'h4
`define TID_MINOR_LSB 4
`define TID_MINOR_VAL 4'h5
`define TID_REVISION_LSB 0
`define TID_CCW_LSB 25
`define TID_CCW_BASE 12
`define TID_DVW_LSB 20
`define TID_DAW_LSB 15
`define TID_VMID_LSB 10
`define TID_CTX_LSB 5
`define TID_UNSUPP_VAL 5'h00
`define TID_IAW_LSB 0
`define TID_IAW_VAL 5'h04
`define TID_OVF_LSB 31
`define TID_OVF_VAL 1'h0
`define TID_PROC_LO_LSB 28
`define TID_PROC_HI_LSB 12
`define TID_SYSTEM_STALL_SUPPORT_LSB 27
`define TID_STALLREG_LSB 26
`define TID_SYNCFIX_LSB 25
`define TID_ERRTRACE_LSB 24
`define TID_FLAG_ON 1'h1
`define TID_NS_EL_LSB 20
`define TID_NS_EL_VAL 4'h0
`define TID_S_EL_LSB 16
`define TID_S_EL_VAL 4'h9
`define TID_MINCC_LSB 0
`define TID_MINCC_VAL 12'h004
`define TID_CTRL_RST 32'h00000000
`define TID_CTRL_STRICT_BIT 0
`define TID_CTRL_HOLD_BIT 1
`define TID_STAT_DECERR_BIT 16
`define TID_STAT_BELOW_BIT 17
`define TID_STAT_CLR_BIT 31
`define TID_COUNT_RST 16'h0000
`define TID_COUNT_MAX 16'hffff
`endif

// File: hw/trace_unit_id_registers.sv
// avalon-mm slave holding the trace unit identification bank
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "trace_id_regs.svh"
module trace_unit_id_registers #(
    parameter logic [7:0] DESIGNER_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h1, // arbitrary value
    parameter int CC_WIDTH = 12,
    parameter int PROC_COUNT = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic [1:0] response,
    output logic waitrequest
);
    // merge written bytes into an old value under byte enables
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] oldValue,
        input logic [31:0] newValue,
        input logic [3:0] enables
    );
        logic [31:0] result;
        result = oldValue;
        for (int i = 0; i < 4; i++)
        begin
            if (enables[i])
            begin
                result[i*8 +: 8] = newValue[i*8 +: 8];
            end
        end
        merge_bytes = result;
    endfunction : merge_bytes

    id_link_if link ();

    // fixed identification words
    id_word_builder #(
        .DESIGNER_CODE(DESIGNER_CODE),
        .REVISION_CODE(REVISION_CODE),
        .CC_WIDTH(CC_WIDTH),
        .PROC_COUNT(PROC_COUNT)
    ) u_words (
        .link(link)
    );

    // address to register selection
    id_addr_decoder u_decoder (
        .link(link)
    );

    // bus handshake state
    trace_id_pkg::bus_state_t state_reg;
    trace_id_pkg::bus_state_t state_next;

    // request captured in idle
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic isWrite_reg;
    logic isWrite_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0] be_reg;
    logic [3:0] be_next;

    // software visible state
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic decErr_reg;
    logic decErr_next;
    logic below_reg;
    logic below_next;
    logic [11:0] thresh_reg;
    logic [11:0] thresh_next;

    // answer flops feeding the outputs
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] resp_reg;
    logic [1:0] resp_next;
    logic wait_reg;
    logic wait_next;

    // handshake decode
    wire idleNow = (state_reg == trace_id_pkg::ST_IDLE);
    wire lookupNow = (state_reg == trace_id_pkg::ST_LOOKUP);
    wire answerNow = (state_reg == trace_id_pkg::ST_ANSWER);
    wire requestNow = idleNow & (read | write);

    // register selection of the captured address
    assign link.lookupAddr = addr_reg;
    wire selArch = (link.sel == trace_id_pkg::SEL_ARCH);
    wire selSize = (link.sel == trace_id_pkg::SEL_SIZE);
    wire selCfg = (link.sel == trace_id_pkg::SEL_CFG);
    wire selCtrl = (link.sel == trace_id_pkg::SEL_CTRL);
    wire selStat = (link.sel == trace_id_pkg::SEL_STAT);
    wire selThresh = (link.sel == trace_id_pkg::SEL_THRESH);
    wire selNone = (link.sel == trace_id_pkg::SEL_NONE);
    wire selIdWord = selArch | selSize | selCfg;

    // write and unmapped-access strobes, each lasting the single lookup cycle
    wire writeNow = lookupNow & isWrite_reg;
    wire idWriteNow = writeNow & selIdWord;
    wire ctrlWriteNow = writeNow & selCtrl;
    wire statWriteNow = writeNow & selStat;
    wire threshWriteNow = writeNow & selThresh;
    wire unmappedNow = lookupNow & selNone;

    // control fields
    wire strictIdWrites = ctrl_reg[`TID_CTRL_STRICT_BIT];
    wire holdCount = ctrl_reg[`TID_CTRL_HOLD_BIT];

    // status write-one-to-clear requests, gated by byte lanes
    wire clrDecErr = statWriteNow & be_reg[2] &
        wdata_reg[`TID_STAT_DECERR_BIT];
    wire clrBelow = statWriteNow & be_reg[2] &
        wdata_reg[`TID_STAT_BELOW_BIT];
    wire clrCount = statWriteNow & be_reg[3] &
        wdata_reg[`TID_STAT_CLR_BIT];

    // threshold candidate; a too small value is raised to the floor
    wire [31:0] threshMerged = merge_bytes({20'h00000, thresh_reg},
        wdata_reg, be_reg);
    wire threshTooLow = (threshMerged[31:12] == 20'h00000) &
        (threshMerged[11:0] < `TID_MINCC_VAL);
    wire [11:0] threshAccepted = (threshMerged[31:12] != 20'h00000) ?
        12'hfff : threshMerged[11:0];

    // ignored-write counter saturates so it never wraps to zero
    wire countCanStep = ~holdCount & (count_reg != `TID_COUNT_MAX);
    wire countStep = idWriteNow & countCanStep;
    wire [15:0] countBase = clrCount ? `TID_COUNT_RST : count_reg;

    // status word layout
    wire [31:0] statWord = {14'h0000, below_reg, decErr_reg, count_reg};

    // read value of the selected register
    wire [31:0] readValue = selArch ? link.archWord :
        selSize ? link.sizeWord :
        selCfg ? link.cfgWord :
        selCtrl ? ctrl_reg :
        selStat ? statWord :
        selThresh ? {20'h00000, thresh_reg} :
        32'h00000000;

    // response code; id words reject writes only when strict is set
    wire [1:0] respValue = selNone ? trace_id_pkg::RESP_DECERR :
        (idWriteNow & strictIdWrites) ? trace_id_pkg::RESP_SLVERR :
        trace_id_pkg::RESP_OKAY;

    // next state: idle, lookup, answer for one cycle, back to idle
    assign state_next = requestNow ? trace_id_pkg::ST_LOOKUP :
        lookupNow ? trace_id_pkg::ST_ANSWER :
        answerNow ? trace_id_pkg::ST_IDLE :
        trace_id_pkg::ST_IDLE;

    // capture the request only in idle so it stays steady
    assign addr_next = requestNow ? address : addr_reg;
    assign isWrite_next = requestNow ? write : isWrite_reg;
    assign wdata_next = requestNow ? writedata : wdata_reg;
    assign be_next = requestNow ? byteenable : be_reg;

    // control register is the only plain read-write word
    assign ctrl_next = ctrlWriteNow ?
        merge_bytes(ctrl_reg, wdata_reg, be_reg) : ctrl_reg;

    // id word writes leave the words alone and only bump the count, unless hold is set or the count is saturated
    assign count_next = countBase + {15'h0000, countStep};

    // sticky flags: a new event wins over a clear in the same cycle
    assign decErr_next = unmappedNow | (decErr_reg & ~clrDecErr);
    assign below_next = (threshWriteNow & threshTooLow) |
        (below_reg & ~clrBelow);

    // threshold never holds less than the documented floor
    assign thresh_next = ~threshWriteNow ? thresh_reg :
        threshTooLow ? `TID_MINCC_VAL : threshAccepted;

    // answer flops: data and response settle as waitrequest drops
    assign rdata_next = (lookupNow & ~isWrite_reg) ? readValue :
        lookupNow ? 32'h00000000 : rdata_reg;
    assign resp_next = lookupNow ? respValue : resp_reg;
    assign wait_next = ~lookupNow;

    // handshake and request capture
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg <= trace_id_pkg::ST_IDLE;
            addr_reg <= 8'h00;
            isWrite_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            be_reg <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            isWrite_reg <= isWrite_next;
            wdata_reg <= wdata_next;
            be_reg <= be_next;
        end
    end

    // software visible state
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `TID_CTRL_RST;
            count_reg <= `TID_COUNT_RST;
            decErr_reg <= 1'b0;
            below_reg <= 1'b0;
            thresh_reg <= `TID_MINCC_VAL;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            decErr_reg <= decErr_next;
            below_reg <= below_next;
            thresh_reg <= thresh_next;
        end
    end

    // answer flops; waitrequest idles high, even in reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 32'h00000000;
            resp_reg <= trace_id_pkg::RESP_OKAY;
            wait_reg <= 1'b1;
        end
        else
        begin
            rdata_reg <= rdata_next;
            resp_reg <= resp_next;
            wait_reg <= wait_next;
        end
    end

    // outputs straight from flops
    assign readdata = rdata_reg;
    assign response = resp_reg;
    assign waitrequest = wait_reg;
endmodule : trace_unit_id_registers

// File: tb/tb.sv
// self-checking bench for the trace id register bank
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] DES = 8'h3c; // arbitrary value
    localparam logic [3:0] REV = 4'h7; // arbitrary value
    localparam logic [31:0] ARCH = {DES, 8'h00, 4'hf, 4'h4, 4'h5, REV};
    localparam logic [31:0] SIZE = {3'h0, 4'h0, 20'h00000, 5'h04};
    localparam logic [31:0] CFG = {1'h0, 3'h0, 4'hf, 4'h0, 4'h9, 2'h0,
        2'h0, 12'h004};
    logic [31:0] idWord [3] = '{ARCH, SIZE, CFG};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic [1:0] response;
    logic waitrequest;
    logic [31:0] expData [$];
    logic [1:0] expResp [$];
    logic [31:0] rnd;
    int miscompares = 0;
    int n_checks = 0;
    int seed = 16;

    trace_unit_id_registers #(.DESIGNER_CODE(DES), .REVISION_CODE(REV),
        .CC_WIDTH(12), .PROC_COUNT(1)) i_trace_unit_id_registers (
        .mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .response(response),
        .waitrequest(waitrequest));

    // 250 MHz clock
    initial
    begin
        forever #2 mclk = ~mclk;
    end

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask : cmp_resp

    // one avalon access; the note goes in before the request rises
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be,
        input logic [31:0] eD, input logic [1:0] eR);
        expData.push_back(eD);
        expResp.push_back(eR);
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        // held until waitrequest is seen low at a rising edge; only the
        // watchdog ends a wait that never completes
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask : access

    task automatic read_ids();
        for (int i = 0; i < 3; i++)
            access(1'b0, 8'(i * 4), 32'h0, 4'hf, idWord[i], 2'h0);
    endtask : read_ids

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // answers are matched against the oldest note at the taking edge
    always @(posedge mclk)
    begin
        if (rst_n && waitrequest === 1'b0)
        begin
            if (expData.size() == 0)
                cmp_word(readdata, 32'hdeadbeef);
            else
            begin
                cmp_word(readdata, expData.pop_front());
                cmp_resp(response, expResp.pop_front());
            end
        end
    end

    // a hang ends the run as a mismatch
    initial
    begin
        #20000;
        miscompares++;
        finish_test();
    end

    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        read_ids();
        access(1'b0, 8'h18, 32'h0, 4'hf, 32'h4, 2'h0);
        $display("test id words done");
        // random writes to id words, then words must be unchanged
        for (int i = 0; i < 3; i++)
        begin
            rnd = $random(seed);
            access(1'b1, 8'(i * 4), rnd, rnd[3:0] | 4'h1, 32'h0, 2'h0);
        end
        read_ids();
        access(1'b0, 8'h14, 32'h0, 4'hf, 32'h3, 2'h0);
        $display("test ignored writes done");
        // unmapped read flags a decode error, then clear flag and count
        access(1'b0, 8'h0c, 32'h0, 4'hf, 32'h0, 2'h3);
        access(1'b0, 8'h14, 32'h0, 4'hf, 32'h00010003, 2'h0);
        access(1'b1, 8'h14, 32'h80010000, 4'hc, 32'h0, 2'h0);
        access(1'b0, 8'h14, 32'h0, 4'hf, 32'h0, 2'h0);
        $display("test decode error done");
        // threshold clamps at the documented minimum of four
        access(1'b1, 8'h18, 32'h2, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h18, 32'h0, 4'hf, 32'h4, 2'h0);
        access(1'b0, 8'h14, 32'h0, 4'hf, 32'h00020000, 2'h0);
        rnd = 32'h4 + ($random(seed) & 32'h7fb);
        access(1'b1, 8'h18, rnd, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h18, 32'h0, 4'hf, rnd, 2'h0);
        access(1'b1, 8'h18, 32'h12345, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h18, 32'h0, 4'hf, 32'hfff, 2'h0);
        $display("test threshold done");
        // strict mode refuses id-word writes, word still unchanged
        access(1'b1, 8'h10, 32'h1, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h10, 32'h0, 4'hf, 32'h1, 2'h0);
        access(1'b1, 8'h08, 32'hffffffff, 4'hf, 32'h0, 2'h2);
        read_ids();
        $display("test strict mode done");
        // hold freezes the ignored-write count; misaligned read is unmapped
        access(1'b1, 8'h10, 32'h2, 4'hf, 32'h0, 2'h0);
        access(1'b1, 8'h04, rnd, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h14, 32'h0, 4'hf, 32'h00020001, 2'h0);
        access(1'b0, 8'h02, 32'h0, 4'hf, 32'h0, 2'h3);
        $display("test count hold done");
        // a mid-run reset restores control, status and threshold
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        access(1'b0, 8'h10, 32'h0, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h14, 32'h0, 4'hf, 32'h0, 2'h0);
        access(1'b0, 8'h18, 32'h0, 4'hf, 32'h4, 2'h0);
        read_ids();
        $display("test mid-run reset done");
        // let the last answer be compared; every note must be used up
        repeat (2) @(posedge mclk);
        cmp_word(32'(expData.size()), 32'h0);
        finish_test();
    end
endmodule : tb

// File: tb/trace_id_asserts.sv
// concurrent checks on the avalon port of the trace id bank
`timescale 1ns/10ps
module trace_id_asserts #(
    parameter logic [7:0] DESIGNER_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h1, // arbitrary value
    parameter int CC_WIDTH = 12,
    parameter int PROC_COUNT = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic [1:0] response,
    input wire logic waitrequest
);
    // expected words rebuilt field by field, not copied from the design
    localparam logic [4:0] PC = 5'(PROC_COUNT - 1);
    localparam logic [31:0] ARCH = {DESIGNER_CODE, 8'h00, 4'hf, 4'h4,
        4'h5, REVISION_CODE};
    localparam logic [31:0] SIZE = {3'h0, 4'(CC_WIDTH - 12), 20'h00000,
        5'h04};
    localparam logic [31:0] CFG = {1'h0, PC[2:0], 4'hf, 4'h0, 4'h9, 2'h0,
        PC[4:3], 12'h004};
    wire logic answer = !waitrequest;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    arch_word_a: assert property (
        answer && read && address == 8'h00 |-> readdata == ARCH
        && response == 2'h0) else $error("architecture word wrong");
    size_word_a: assert property (
        answer && read && address == 8'h04 |-> readdata == SIZE
        && response == 2'h0) else $error("size word wrong");
    config_word_a: assert property (
        answer && read && address == 8'h08 |-> readdata == CFG
        && response == 2'h0) else $error("configuration word wrong");
    write_answer_a: assert property (
        answer && write |-> readdata == 32'h00000000)
        else $error("write answer carries data");
    decode_error_a: assert property (
        answer && read && address == 8'h0c |-> response == 2'h3
        && readdata == 32'h00000000) else $error("unmapped read answered");
    answer_pulse_a: assert property (
        answer |=> waitrequest) else $error("answer longer than a cycle");
    answer_cause_a: assert property (
        $fell(waitrequest) |-> (read || write) && $past(read || write, 2))
        else $error("answer without its request");
    data_hold_a: assert property (
        $rose(waitrequest) |-> $stable(readdata) && $stable(response))
        else $error("answer data not held");
    idle_wait_a: assert property (
        !read && !write |-> waitrequest) else $error("answer while idle");
endmodule : trace_id_asserts

bind trace_unit_id_registers trace_id_asserts #(
    .DESIGNER_CODE(DESIGNER_CODE),
    .REVISION_CODE(REVISION_CODE),
    .CC_WIDTH(CC_WIDTH),
    .PROC_COUNT(PROC_COUNT)
) i_trace_id_asserts (.mclk(mclk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .response(response),
    .waitrequest(waitrequest));
